// >>> rtl/ubr_defines.vh
// register map, field positions, reset values and state codes of the uart break/receiver
//
// How it works
// - status read then data write clears both
// - break armed after divisor+3 clocks while idle
// - break: start, thirteen-multiple lows, stops
// - break repeats while requested, then stop bits
// - break frames raise no transmit interrupt
// - eight or nine bit words, ninth kept
// - sixteen-times oversampling, three-sample majority vote
// - stop sampled, word pushed if room
// - received bits shifted least significant first
// - two-entry receive fifo plus shifter
// - overrun: flag, keep fifo, interrupt request
// - receive enable starts start-bit hunt
// - data-available flag, push raises interrupt request
// - status read then data read clears
// - break received as framing error, zeros
// - wait for high before next hunt
// - receiver idle low only inside frame
// - noise flag rises with data available
// - low stop position sets framing error
// - parity mismatch flagged only when enabled
// - framing error cleared by any reset
// - disable empties fifo, clears, sets idles
// - receiver expects one stop bit only
`ifndef UBR_DEFINES_VH
`define UBR_DEFINES_VH

// ***************
// register offsets
// ***************
`define UBR_ADDR_CTRL     4'h0
`define UBR_ADDR_STATUS   4'h4
`define UBR_ADDR_DATA     4'h8
`define UBR_ADDR_BAUD     4'hC

// ***************
// control fields
// ***************
`define UBR_C_SEN   0
`define UBR_C_REN   1
`define UBR_C_TEN   2
`define UBR_C_BRK   3
`define UBR_C_WLS   4
`define UBR_C_PEN   5
`define UBR_C_PODD  6
`define UBR_C_STOP2 7
`define UBR_C_RIE   8
`define UBR_C_TX9   9
`define UBR_CTRL_RST 10'h000
`define UBR_BAUD_RST 8'h00

// ***************
// status fields
// ***************
`define UBR_S_PERR  0
`define UBR_S_NF    1
`define UBR_S_FERR  2
`define UBR_S_OERR  3
`define UBR_S_RIDLE 4
`define UBR_S_RXAV  5
`define UBR_S_TIDLE 6
`define UBR_S_TXE   7
`define UBR_S_RX9   8

// ***************
// timing
// ***************
`define UBR_OVS_LAST  4'hF
`define UBR_VOTE_A    4'h7
`define UBR_VOTE_B    4'h8
`define UBR_VOTE_C    4'h9
`define UBR_BRK_BITS  4'hC

// ***************
// states
// ***************
`define UBR_T_IDLE  3'h0
`define UBR_T_START 3'h1
`define UBR_T_DATA  3'h2
`define UBR_T_STOP  3'h3
`define UBR_T_BRK   3'h4
`define UBR_R_HUNT  3'h0
`define UBR_R_START 3'h1
`define UBR_R_DATA  3'h2
`define UBR_R_STOP  3'h3
`define UBR_R_WAITH 3'h4

`endif

// >>> rtl/ubr_uart.v
// uart break transmitter and oversampling receiver with axi4-lite register access
`timescale 1ns/1ps
`include "ubr_defines.vh"

module ubr_uart (
    clk,
    rst_b,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    serial_receive_line,
    serial_transmit_line,
    rx_irq
);
    input  wire        clk;
    input  wire        rst_b;
    input  wire [3:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [3:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        serial_receive_line;
    output reg         serial_transmit_line;
    output reg         rx_irq;

    // ***************
    // functions
    // ***************
    function parity_of;
        input [8:0] d;
        input       nine;
        input       odd;
        begin
            parity_of = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
        end
    endfunction

    function [3:0] word_bits;
        input nine;
        begin
            word_bits = nine ? 4'h9 : 4'h8;
        end
    endfunction

    // ***************
    // registers
    // ***************
    reg  [9:0]  ctrl_reg;
    reg  [7:0]  baud_divisor;
    reg  [7:0]  div_cnt_reg;
    reg         tick16;
    reg  [8:0]  tx_hold_reg;
    reg         tx_buffer_empty_flag;
    reg         tx_idle_flag;
    reg         tx_seen_reg;
    reg         rx_seen_reg;
    reg  [2:0]  tx_state_reg;
    reg  [3:0]  tx_sub_reg;
    reg  [3:0]  tx_bit_reg;
    reg  [8:0]  tx_shift_register;
    reg  [8:0]  brk_cnt_reg;
    reg         brk_armed_reg;
    reg         rx_meta_reg;
    reg         rx_sync_reg;
    reg  [2:0]  rx_state_reg;
    reg  [3:0]  rx_sub_reg;
    reg  [3:0]  rx_bit_reg;
    reg  [8:0]  rx_shift_register;
    reg  [1:0]  vote_reg;
    reg         frame_noise_reg;
    reg         rx_idle_flag;
    reg  [10:0] fifo_mem [0:1];
    reg         fifo_wp_reg;
    reg         fifo_rp_reg;
    reg  [1:0]  fifo_cnt_reg;
    reg         overrun_flag;
    reg         noise_flag;

    wire serial_enable_bit  = ctrl_reg[`UBR_C_SEN];
    wire rx_enable_bit      = ctrl_reg[`UBR_C_REN];
    wire tx_enable_bit      = ctrl_reg[`UBR_C_TEN];
    wire break_request_bit  = ctrl_reg[`UBR_C_BRK];
    wire word_length_select = ctrl_reg[`UBR_C_WLS];
    wire parity_enable_bit  = ctrl_reg[`UBR_C_PEN];
    wire parity_type_select = ctrl_reg[`UBR_C_PODD];
    wire rx_interrupt_enable = ctrl_reg[`UBR_C_RIE];
    wire rx_data_available_flag = (fifo_cnt_reg != 2'h0);
    wire [10:0] fifo_head   = fifo_mem[fifo_rp_reg];

    // ***************
    // axi4-lite slave
    // ***************
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_ctrl   = wr_go & (s_axi_awaddr == `UBR_ADDR_CTRL);
    wire wr_baud   = wr_go & (s_axi_awaddr == `UBR_ADDR_BAUD) & s_axi_wstrb[0];
    wire wr_data   = wr_go & (s_axi_awaddr == `UBR_ADDR_DATA) & (s_axi_wstrb[1:0] == 2'h3);
    wire wr_ok     = (s_axi_awaddr == `UBR_ADDR_CTRL) | (s_axi_awaddr == `UBR_ADDR_BAUD) |
                     (s_axi_awaddr == `UBR_ADDR_DATA) | (s_axi_awaddr == `UBR_ADDR_STATUS);
    wire rd_status = rd_go & (s_axi_araddr == `UBR_ADDR_STATUS);
    wire rd_data   = rd_go & (s_axi_araddr == `UBR_ADDR_DATA);
    // writes while the buffer is full are dropped, never corrupting a pending word
    wire tx_accept = wr_data & tx_seen_reg & tx_buffer_empty_flag;
    wire rx_pop    = rd_data & rx_seen_reg & rx_data_available_flag;

    reg [9:0]  ctrl_wr;
    reg [31:0] rd_mux;
    always @* begin
        ctrl_wr = ctrl_reg;
        if (s_axi_wstrb[0])
            ctrl_wr[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
            ctrl_wr[9:8] = s_axi_wdata[9:8];
        if (!ctrl_wr[`UBR_C_SEN]) begin
            ctrl_wr[`UBR_C_REN] = 1'b0;
            ctrl_wr[`UBR_C_TEN] = 1'b0;
            ctrl_wr[`UBR_C_BRK] = 1'b0;
        end
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `UBR_ADDR_CTRL:   rd_mux[9:0] = ctrl_reg;
            `UBR_ADDR_BAUD:   rd_mux[7:0] = baud_divisor;
            `UBR_ADDR_DATA:   rd_mux[8:0] = fifo_head[8:0];
            `UBR_ADDR_STATUS: begin
                rd_mux[`UBR_S_PERR]  = rx_data_available_flag & fifo_head[10];
                rd_mux[`UBR_S_NF]    = noise_flag;
                rd_mux[`UBR_S_FERR]  = rx_data_available_flag & fifo_head[9];
                rd_mux[`UBR_S_OERR]  = overrun_flag;
                rd_mux[`UBR_S_RIDLE] = rx_idle_flag;
                rd_mux[`UBR_S_RXAV]  = rx_data_available_flag;
                rd_mux[`UBR_S_TIDLE] = tx_idle_flag;
                rd_mux[`UBR_S_TXE]   = tx_buffer_empty_flag;
                rd_mux[`UBR_S_RX9]   = rx_data_available_flag & fifo_head[8];
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0000_0000;
            ctrl_reg     <= `UBR_CTRL_RST;
            baud_divisor <= `UBR_BAUD_RST;
            tx_seen_reg  <= 1'b0;
            rx_seen_reg  <= 1'b0;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (wr_ctrl)
                ctrl_reg <= ctrl_wr;
            if (wr_baud)
                baud_divisor <= s_axi_wdata[7:0];
            // a status read arms the clearing read or write that follows it
            if (rd_status)
                tx_seen_reg <= 1'b1;
            else if (wr_data)
                tx_seen_reg <= 1'b0;
            if (rd_status)
                rx_seen_reg <= 1'b1;
            else if (rd_data)
                rx_seen_reg <= 1'b0;
        end
    end

    // ***************
    // baud divider
    // ***************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg <= 8'h00;
            tick16      <= 1'b0;
        end else if (!serial_enable_bit) begin
            div_cnt_reg <= 8'h00;
            tick16      <= 1'b0;
        end else if (div_cnt_reg == baud_divisor) begin
            div_cnt_reg <= 8'h00;
            tick16      <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
            tick16      <= 1'b0;
        end
    end

    // ***************
    // transmitter
    // ***************
    wire tx_bit_end = tick16 & (tx_sub_reg == `UBR_OVS_LAST);
    wire [8:0] tx_load = parity_enable_bit ?
        (word_length_select ? {parity_of(tx_hold_reg, 1'b1, parity_type_select), tx_hold_reg[7:0]}
                            : {1'b0, parity_of(tx_hold_reg, 1'b0, parity_type_select),
                               tx_hold_reg[6:0]}) : tx_hold_reg;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state_reg         <= `UBR_T_IDLE;
            tx_sub_reg           <= 4'h0;
            tx_bit_reg           <= 4'h0;
            tx_shift_register    <= 9'h000;
            tx_hold_reg          <= 9'h000;
            tx_buffer_empty_flag <= 1'b1;
            tx_idle_flag         <= 1'b1;
            brk_cnt_reg          <= 9'h000;
            brk_armed_reg        <= 1'b0;
            serial_transmit_line <= 1'b1;
        end else if (!serial_enable_bit || !tx_enable_bit) begin
            tx_state_reg         <= `UBR_T_IDLE;
            tx_sub_reg           <= 4'h0;
            tx_bit_reg           <= 4'h0;
            serial_transmit_line <= 1'b1;
            brk_cnt_reg          <= 9'h000;
            brk_armed_reg        <= 1'b0;
            if (!serial_enable_bit) begin
                tx_buffer_empty_flag <= 1'b1;
                tx_idle_flag         <= 1'b1;
            end else if (tx_accept) begin
                tx_hold_reg          <= {ctrl_reg[`UBR_C_TX9], s_axi_wdata[7:0]};
                tx_buffer_empty_flag <= 1'b0;
                tx_idle_flag         <= 1'b0;
            end
        end else begin
            if (tx_accept) begin
                tx_hold_reg          <= {ctrl_reg[`UBR_C_TX9], s_axi_wdata[7:0]};
                tx_buffer_empty_flag <= 1'b0;
                tx_idle_flag         <= 1'b0;
            end
            // break must be held past one divider period while idle before it arms
            if (!break_request_bit) begin
                brk_cnt_reg   <= 9'h000;
                brk_armed_reg <= 1'b0;
            end else if (tx_idle_flag && !brk_armed_reg) begin
                if (brk_cnt_reg > {1'b0, baud_divisor} + 9'h001)
                    brk_armed_reg <= 1'b1;
                else
                    brk_cnt_reg <= brk_cnt_reg + 9'h001;
            end
            if (tick16 && tx_state_reg != `UBR_T_IDLE)
                tx_sub_reg <= tx_sub_reg + 4'h1;
            case (tx_state_reg)
                `UBR_T_IDLE: begin
                    tx_sub_reg <= 4'h0;
                    tx_bit_reg <= 4'h0;
                    if (brk_armed_reg) begin
                        tx_state_reg         <= `UBR_T_BRK;
                        tx_bit_reg           <= 4'hF;
                        tx_idle_flag         <= 1'b0;
                        serial_transmit_line <= 1'b0;
                    end else if (!tx_buffer_empty_flag && !tx_accept) begin
                        tx_shift_register    <= tx_load;
                        tx_buffer_empty_flag <= 1'b1;
                        tx_idle_flag         <= 1'b0;
                        tx_state_reg         <= `UBR_T_START;
                        serial_transmit_line <= 1'b0;
                    end
                end
                `UBR_T_START: if (tx_bit_end) begin
                    tx_state_reg         <= `UBR_T_DATA;
                    serial_transmit_line <= tx_shift_register[0];
                end
                `UBR_T_DATA: if (tx_bit_end) begin
                    tx_shift_register <= {1'b0, tx_shift_register[8:1]};
                    if (tx_bit_reg == word_bits(word_length_select) - 4'h1) begin
                        tx_bit_reg           <= 4'h0;
                        tx_state_reg         <= `UBR_T_STOP;
                        serial_transmit_line <= 1'b1;
                    end else begin
                        tx_bit_reg           <= tx_bit_reg + 4'h1;
                        serial_transmit_line <= tx_shift_register[1];
                    end
                end
                // count from -1: start bit, then thirteen lows
                `UBR_T_BRK: if (tx_bit_end) begin
                    if (tx_bit_reg == `UBR_BRK_BITS) begin
                        tx_bit_reg <= 4'h0;
                        if (!break_request_bit) begin
                            tx_state_reg         <= `UBR_T_STOP;
                            serial_transmit_line <= 1'b1;
                        end
                    end else
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                end
                `UBR_T_STOP: if (tx_bit_end) begin
                    if (ctrl_reg[`UBR_C_STOP2] && tx_bit_reg == 4'h0)
                        tx_bit_reg <= 4'h1;
                    else begin
                        tx_state_reg  <= `UBR_T_IDLE;
                        tx_idle_flag  <= 1'b1;
                        brk_armed_reg <= 1'b0;
                        brk_cnt_reg   <= 9'h000;
                    end
                end
                default: tx_state_reg <= `UBR_T_IDLE;
            endcase
        end
    end

    // ***************
    // receiver
    // ***************
    wire [3:0] rx_nb  = word_bits(word_length_select);
    wire       sample = tick16 & (rx_sub_reg == `UBR_VOTE_C);
    // majority of samples at ticks seven, eight and nine around the bit centre
    wire       voted  = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rx_sync_reg) |
                        (vote_reg[1] & rx_sync_reg);
    wire       vote_noisy = ~((vote_reg[0] == vote_reg[1]) & (vote_reg[1] == rx_sync_reg));
    wire       rx_bad_par = parity_enable_bit &
                            (rx_shift_register[rx_nb - 4'h1] !=
                             parity_of(rx_shift_register, word_length_select, parity_type_select));
    wire       frame_done = (rx_state_reg == `UBR_R_STOP) & sample;
    wire       fifo_full  = (fifo_cnt_reg == 2'h2);
    wire       push       = frame_done & ~fifo_full;
    wire       overrun    = frame_done & fifo_full;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_receive_line;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_reg      <= `UBR_R_HUNT;
            rx_sub_reg        <= 4'h0;
            rx_bit_reg        <= 4'h0;
            rx_shift_register <= 9'h000;
            vote_reg          <= 2'h3;
            frame_noise_reg   <= 1'b0;
            rx_idle_flag      <= 1'b1;
        end else if (!serial_enable_bit || !rx_enable_bit) begin
            rx_state_reg <= `UBR_R_HUNT;
            rx_sub_reg   <= 4'h0;
            rx_idle_flag <= 1'b1;
        end else begin
            if (tick16) begin
                rx_sub_reg <= rx_sub_reg + 4'h1;
                if (rx_sub_reg == `UBR_VOTE_A)
                    vote_reg[0] <= rx_sync_reg;
                if (rx_sub_reg == `UBR_VOTE_B)
                    vote_reg[1] <= rx_sync_reg;
            end
            case (rx_state_reg)
                `UBR_R_HUNT: begin
                    rx_sub_reg <= 4'h0;
                    if (!rx_sync_reg) begin
                        rx_state_reg    <= `UBR_R_START;
                        rx_idle_flag    <= 1'b0;
                        frame_noise_reg <= 1'b0;
                        rx_bit_reg      <= 4'h0;
                    end
                end
                `UBR_R_START: if (sample) begin
                    if (voted) begin
                        rx_state_reg <= `UBR_R_HUNT;
                        rx_idle_flag <= 1'b1;
                    end else begin
                        rx_state_reg      <= `UBR_R_DATA;
                        rx_shift_register <= 9'h000;
                        frame_noise_reg   <= vote_noisy;
                    end
                end
                `UBR_R_DATA: if (sample) begin
                    rx_shift_register[rx_bit_reg] <= voted;
                    frame_noise_reg <= frame_noise_reg | vote_noisy;
                    if (rx_bit_reg == rx_nb - 4'h1)
                        rx_state_reg <= `UBR_R_STOP;
                    else
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                end
                // a single stop position is checked whatever the transmit setting
                `UBR_R_STOP: if (sample) begin
                    rx_idle_flag <= 1'b1;
                    rx_state_reg <= voted ? `UBR_R_HUNT : `UBR_R_WAITH;
                end
                // a held break must not be taken for the next start bit
                `UBR_R_WAITH: if (rx_sync_reg)
                    rx_state_reg <= `UBR_R_HUNT;
                default: rx_state_reg <= `UBR_R_HUNT;
            endcase
        end
    end

    // ***************
    // receive fifo and flags
    // ***************
    integer i;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 2; i = i + 1)
                fifo_mem[i] <= 11'h000;
            fifo_wp_reg  <= 1'b0;
            fifo_rp_reg  <= 1'b0;
            fifo_cnt_reg <= 2'h0;
            overrun_flag <= 1'b0;
            noise_flag   <= 1'b0;
            rx_irq       <= 1'b0;
        end else if (!serial_enable_bit) begin
            fifo_wp_reg  <= 1'b0;
            fifo_rp_reg  <= 1'b0;
            fifo_cnt_reg <= 2'h0;
            overrun_flag <= 1'b0;
            noise_flag   <= 1'b0;
            rx_irq       <= 1'b0;
        end else begin
            if (push) begin
                // a break lands here as all zeros with framing error set
                fifo_mem[fifo_wp_reg] <= {rx_bad_par, ~voted, rx_shift_register};
                fifo_wp_reg <= ~fifo_wp_reg;
            end
            if (rx_pop)
                fifo_rp_reg <= ~fifo_rp_reg;
            if (push && !rx_pop)
                fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
            else if (rx_pop && !push)
                fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
            // a new event in the clearing cycle wins over the clear
            if (overrun)
                overrun_flag <= 1'b1;
            else if (rx_pop)
                overrun_flag <= 1'b0;
            if (push && (frame_noise_reg || vote_noisy))
                noise_flag <= 1'b1;
            else if (rx_pop)
                noise_flag <= 1'b0;
            rx_irq <= rx_interrupt_enable & (push | overrun);
        end
    end

endmodule // ubr_uart

// >>> tb/ubr_remote_tx.sv
// remote uart transmitter model driving the receive line
`timescale 1ns/1ps
module ubr_remote_tx (
    input  wire  clk,
    output logic line
);
    initial line = 1'b1; // mark level while no frame
    // divisor zero: one bit is sixteen clocks
    task automatic bit_out(input logic v);
        line <= v;
        repeat (16) @(posedge clk);
    endtask
    // start, n word bits, one stop at the given level
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        @(posedge clk);
        bit_out(1'b0);
        for (int i = 0; i < n; i++) bit_out(d[i]);
        bit_out(stp);
        line <= 1'b1;
    endtask
    // long low, then a full bit of mark so the far end may rearm
    task automatic brk(input int nb);
        @(posedge clk);
        repeat (nb) bit_out(1'b0);
        bit_out(1'b1);
    endtask
endmodule // ubr_remote_tx

// >>> tb/ubr_uart_asserts.sv
// bus handshake and receive pulse checker for the uart block
`timescale 1ns/1ps
module ubr_uart_asserts (
    input wire        clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire        s_axi_rvalid, s_axi_rready, rx_irq,
    input wire [3:0]  s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_bresp, s_axi_rresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_bvalid) else $error("write not answered");
    chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_ready_pair: assert property (s_axi_awready == s_axi_wready and (s_axi_awready
        |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("ready mismatch");
    chk_align_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == 2'h0) else $error("aligned read not okay");
    chk_align_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == 2'h2) else $error("misaligned read not refused");
    chk_irq_pulse: assert property (rx_irq |=> !rx_irq [*8])
        else $error("receive pulse too long");
    cover property (rx_irq);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ubr_uart_asserts
bind ubr_uart ubr_uart_asserts u_ubr_uart_asserts (.*);

// >>> tb/uart_break_and_receiver_tb_top.sv
// self-checking bench for the uart receiver and its register bus
`timescale 1ns/1ps
`include "ubr_defines.vh"
module uart_break_and_receiver_tb_top;
    logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, arready, bvalid, rvalid, irq, txd, rxd;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd_d;
    logic [1:0]  bresp, rresp, rd_r;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    ubr_uart u_ubr_uart (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_receive_line(rxd), .serial_transmit_line(txd),
        .rx_irq(irq));
    ubr_remote_tx u_ubr_remote_tx (.clk(clk), .line(rxd));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************
    // bus tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do @(posedge clk); while (awready !== 1'b1);
        {awvalid, wvalid} <= 2'h0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        {rd_d, rd_r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, rd_d, e);
        chk(nm, {30'h0, rd_r}, 32'h0);
    endtask
    // bounded wait: a frame is under two hundred clocks
    task automatic wirq;
        for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
        chk("rx_irq", {31'h0, irq}, 32'h1);
    endtask
    task automatic rcv(input logic [8:0] d, input int n);
        fork
            u_ubr_remote_tx.send(d, n, 1'b1);
            wirq;
        join
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done;
        end
    end
    // ****************
    // tests
    // ****************
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`UBR_ADDR_STATUS, 32'hD0, "status reset");
        rd(4'h1);
        chk("misaligned resp", {30'h0, rd_r}, 32'h2);
        $display("test registers done");
        wr(`UBR_ADDR_CTRL, 32'h103);
        rcv(9'h0A5, 8);
        rdc(`UBR_ADDR_STATUS, 32'hF0, "status one word");
        rdc(`UBR_ADDR_DATA, 32'hA5, "data one word");
        rdc(`UBR_ADDR_STATUS, 32'hD0, "status drained");
        $display("test single word done");
        rcv(9'h011, 8);
        rcv(9'h022, 8);
        rcv(9'h033, 8);
        rdc(`UBR_ADDR_STATUS, 32'hF8, "status overrun");
        rdc(`UBR_ADDR_DATA, 32'h11, "data first");
        rdc(`UBR_ADDR_STATUS, 32'hF0, "status after pop");
        rdc(`UBR_ADDR_DATA, 32'h22, "data second");
        $display("test overrun done");
        fork
            u_ubr_remote_tx.brk(20);
            wirq;
        join
        rdc(`UBR_ADDR_STATUS, 32'hF4, "status break");
        rdc(`UBR_ADDR_DATA, 32'h0, "data break");
        rcv(9'h05A, 8);
        rdc(`UBR_ADDR_STATUS, 32'hF0, "status after break");
        wr(`UBR_ADDR_CTRL, 32'h10F);
        wr(`UBR_ADDR_CTRL, 32'h107);
        repeat (215) @(posedge clk);
        chk("txd", {31'h0, txd}, 32'h0);
        repeat (40) @(posedge clk);
        chk("txd", {31'h0, txd}, 32'h1);
        wr(`UBR_ADDR_CTRL, 32'h100);
        rdc(`UBR_ADDR_STATUS, 32'hD0, "status disabled");
        $display("test break done");
        wr(`UBR_ADDR_CTRL, 32'h133);
        rcv(9'h1A5, 9);
        rdc(`UBR_ADDR_STATUS, 32'h1F1, "status parity");
        rdc(`UBR_ADDR_DATA, 32'h1A5, "data nine bit");
        $display("test nine bit done");
        test_done;
    end
endmodule // uart_break_and_receiver_tb_top
